/* File: smc_pkg.sv */
// shared constants and types for the two-wire configuration link
package smc_pkg;

	// slave address, seven bits, write byte 8'hD2 on the wire
	localparam logic [6:0] SMC_DEV_ADDR   = 7'h69;
	localparam int         SMC_CMD_BYTE_BIT = 7;
	localparam int         SMC_NBYTES     = 8;

	// power-up values of the configuration bytes, and the value read past the last byte
	localparam logic [7:0] SMC_DEF_BYTE0  = 8'h00;
	localparam logic [7:0] SMC_DEF_BYTE1  = 8'hFF;
	localparam logic [7:0] SMC_DEF_BYTE2  = 8'h7F;
	localparam logic [7:0] SMC_DEF_OTHER  = 8'h00;
	localparam logic [7:0] SMC_RD_EMPTY   = 8'h00;

	// clock buffer enables: all of byte 1, bits 6..0 of byte 2
	localparam int         SMC_EN_BYTE_A  = 1;
	localparam int         SMC_EN_BYTE_B  = 2;
	localparam int         SMC_EN_B_W     = 7;
	localparam int         SMC_OUT_EN_W   = 8 + SMC_EN_B_W;

	// link timing: host divides mclk into four quarters per bit
	localparam int         SMC_MCLK_NS    = 25;
	localparam int         SMC_SCL_PERIOD_NS = 200;
	localparam int         SMC_QTR_CYC_I  =
		(SMC_SCL_PERIOD_NS / (4 * SMC_MCLK_NS)) < 1 ? 1 :
		SMC_SCL_PERIOD_NS / (4 * SMC_MCLK_NS);
	localparam logic [7:0] SMC_QTR_CYC    = 8'(SMC_QTR_CYC_I);

	// bit counter value of the acknowledge slot
	localparam logic [3:0] SMC_ACK_SLOT   = 4'h8;

	typedef enum logic [1:0] {
		SMC_OP_BYTE_WR,
		SMC_OP_BYTE_RD,
		SMC_OP_BLK_WR,
		SMC_OP_BLK_RD
	} smc_op_e;

	function automatic logic [7:0] smc_default(input int i);
		if (i == 0)
			return SMC_DEF_BYTE0;
		else if (i == SMC_EN_BYTE_A)
			return SMC_DEF_BYTE1;
		else if (i == SMC_EN_BYTE_B)
			return SMC_DEF_BYTE2;
		else
			return SMC_DEF_OTHER;
	endfunction

endpackage

/* File: smc_link_if.sv */
// two-wire link between host and configuration slave
`timescale 1ns/100ps
interface smc_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// wired-and of the open-drain data line, released level is high
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
	             (dev_sda_oe ? dev_sda_o : 1'b1);

	modport host (output scl, output host_sda_o, output host_sda_oe,
	              input sda);
	modport device (input scl, input sda, output dev_sda_o,
	                output dev_sda_oe);
endinterface

/* File: smc_dev.sv */
// configuration slave: link engine on scl, byte mirror on mclk
`timescale 1ns/100ps
module smc_dev
	import smc_pkg::*;
#(
	parameter int NBYTES = SMC_NBYTES
) (
	// link
	smc_link_if.device                link,
	// user side
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 cfg_hold,
	// configuration mirror
	output logic [NBYTES*8-1:0]       cfg_bytes,
	output logic [SMC_OUT_EN_W-1:0]   out_en,
	output logic                      wr_pending
);

	localparam logic [7:0] NB8 = 8'(NBYTES);

	typedef enum {S_IDLE, S_ADDR, S_CMD, S_CNT, S_WDATA, S_TX} smc_dst_e;

	// start detect, clocked by the data line itself
	logic start_tog_q, start_tog_d;

	// scl domain
	smc_dst_e   st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [6:0] idx_q, idx_d;
	logic       blk_q, blk_d;
	logic       ack_q, ack_d;
	logic       seen_q, seen_d;
	logic [7:0] cfg_q [NBYTES];
	logic [7:0] cfg_d [NBYTES];
	logic [14:0] mem_q [2];
	logic [14:0] mem_d [2];
	logic [1:0] wbin_q, wbin_d;
	logic [1:0] wgray_q;
	logic [1:0] rg_s1_q, rg_s2_q;
	logic       full;
	logic [7:0] rx_byte;
	logic       oe_q, oe_d;

	// mclk domain
	logic [1:0] rbin_q, rbin_d;
	logic [1:0] rgray_q;
	logic [1:0] wg_s1_q, wg_s2_q;
	logic [7:0] cfgm_q [NBYTES];
	logic [7:0] cfgm_d [NBYTES];
	logic       pop;
	logic [14:0] rd_word;

	function automatic logic [1:0] gray(input logic [1:0] b);
		return b ^ {1'b0, b[1]};
	endfunction

	function automatic logic [7:0] rd_byte(input logic [6:0] i);
		logic [7:0] v;
		v = SMC_RD_EMPTY;
		for (int k = 0; k < NBYTES; k++) begin
			if (7'(k) == i)
				v = cfg_q[k];
		end
		return v;
	endfunction

	// a start is a falling data edge while scl is high
	always_comb begin
		start_tog_d = link.scl ? ~start_tog_q : start_tog_q;
	end

	always_ff @(negedge link.sda or posedge rst) begin
		if (rst)
			start_tog_q <= 1'b0;
		else
			start_tog_q <= start_tog_d;
	end

	// full compares against the read pointer two scl edges old, so it
	// errs toward full; a full buffer nacks the data byte
	assign full    = gray(wbin_q) == ~rg_s2_q;
	assign rx_byte = {sh_q[6:0], link.sda};

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		tx_d   = tx_q;
		idx_d  = idx_q;
		blk_d  = blk_q;
		ack_d  = ack_q;
		seen_d = seen_q;
		cfg_d  = cfg_q;
		mem_d  = mem_q;
		wbin_d = wbin_q;
		if (start_tog_q != seen_q) begin
			// first address bit after a start or repeated start
			seen_d = start_tog_q;
			st_d   = S_ADDR;
			sh_d   = {7'h00, link.sda};
			cnt_d  = 4'h1;
			ack_d  = 1'b0;
		end else if (cnt_q == SMC_ACK_SLOT) begin
			cnt_d = 4'h0;
			ack_d = 1'b0;
			if (!ack_q && st_q == S_TX) begin
				if (!link.sda) begin
					tx_d  = rd_byte(idx_q);
					idx_d = idx_q + 7'h01;
				end else begin
					st_d = S_IDLE;
				end
			end
		end else begin
			cnt_d = cnt_q + 4'h1;
			sh_d  = rx_byte;
			if (st_q == S_TX) begin
				tx_d = {tx_q[6:0], 1'b0};
			end else if (cnt_q == 4'h7) begin
				case (st_q)
					S_ADDR: begin
						if (rx_byte[7:1] == SMC_DEV_ADDR) begin
							ack_d = 1'b1;
							if (rx_byte[0]) begin
								st_d = S_TX;
								if (blk_q) begin
									tx_d  = NB8;
									idx_d = 7'h00;
								end else begin
									tx_d = rd_byte(idx_q);
								end
							end else begin
								st_d = S_CMD;
							end
						end else begin
							st_d = S_IDLE;
						end
					end
					S_CMD: begin
						ack_d = 1'b1;
						blk_d = ~rx_byte[SMC_CMD_BYTE_BIT];
						if (rx_byte[SMC_CMD_BYTE_BIT]) begin
							idx_d = rx_byte[6:0];
							st_d  = S_WDATA;
						end else begin
							// low bits are zero block starts at 0
							idx_d = 7'h00;
							st_d  = S_CNT;
						end
					end
					S_CNT: begin
						ack_d = 1'b1;
						st_d  = S_WDATA;
					end
					S_WDATA: begin
						if (8'(idx_q) < NB8 && !full) begin
							ack_d = 1'b1;
							// each byte commits on its own, so a stop
							// after it leaves later bytes untouched
							for (int k = 0; k < NBYTES; k++) begin
								if (7'(k) == idx_q)
									cfg_d[k] = rx_byte;
							end
							mem_d[wbin_q[0]] = {idx_q, rx_byte};
							wbin_d = wbin_q + 2'h1;
							idx_d  = idx_q + 7'h01;
							if (!blk_q)
								st_d = S_IDLE;
						end else begin
							st_d = S_IDLE;
						end
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge link.scl or posedge rst) begin
		if (rst) begin
			st_q    <= S_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			idx_q   <= 7'h00;
			blk_q   <= 1'b0;
			ack_q   <= 1'b0;
			seen_q  <= 1'b0;
			wbin_q  <= 2'h0;
			wgray_q <= 2'h0;
			rg_s1_q <= 2'h0;
			rg_s2_q <= 2'h0;
			mem_q[0] <= 15'h0000;
			mem_q[1] <= 15'h0000;
			for (int k = 0; k < NBYTES; k++)
				cfg_q[k] <= smc_default(k);
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			idx_q   <= idx_d;
			blk_q   <= blk_d;
			ack_q   <= ack_d;
			seen_q  <= seen_d;
			wbin_q  <= wbin_d;
			// pointers cross as registered gray so no decode glitch is caught
			wgray_q <= gray(wbin_d);
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
			mem_q   <= mem_d;
			cfg_q   <= cfg_d;
		end
	end

	// drive only on the falling edge so data is stable while scl is high
	always_comb begin
		oe_d = (cnt_q == SMC_ACK_SLOT && ack_q) ||
		       (st_q == S_TX && cnt_q != SMC_ACK_SLOT && !tx_q[7]);
	end

	always_ff @(negedge link.scl or posedge rst) begin
		if (rst)
			oe_q <= 1'b0;
		else
			oe_q <= oe_d;
	end

	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = oe_q;

	// mclk side drains the buffer into the mirror; cfg_hold stalls it
	assign pop     = gray(rbin_q) != wg_s2_q && !cfg_hold;
	assign rd_word = mem_q[rbin_q[0]];

	always_comb begin
		rbin_d = rbin_q;
		cfgm_d = cfgm_q;
		if (pop) begin
			rbin_d = rbin_q + 2'h1;
			for (int k = 0; k < NBYTES; k++) begin
				if (7'(k) == rd_word[14:8])
					cfgm_d[k] = rd_word[7:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rbin_q  <= 2'h0;
			rgray_q <= 2'h0;
			wg_s1_q <= 2'h0;
			wg_s2_q <= 2'h0;
			for (int k = 0; k < NBYTES; k++)
				cfgm_q[k] <= smc_default(k);
		end else begin
			rbin_q  <= rbin_d;
			rgray_q <= gray(rbin_d);
			wg_s1_q <= wgray_q;
			wg_s2_q <= wg_s1_q;
			cfgm_q  <= cfgm_d;
		end
	end

	generate
		for (genvar g = 0; g < NBYTES; g++) begin : g_out
			assign cfg_bytes[g*8 +: 8] = cfgm_q[g];
		end
	endgenerate

	assign out_en = {cfgm_q[SMC_EN_BYTE_B][SMC_EN_B_W-1:0],
	                 cfgm_q[SMC_EN_BYTE_A]};
	assign wr_pending = gray(rbin_q) != wg_s2_q;

endmodule

/* File: smc_host.sv */
// host end: bit-level master that runs one transaction per command
`timescale 1ns/100ps
module smc_host
	import smc_pkg::*;
(
	// link
	smc_link_if.host                  link,
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// command
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire smc_op_e              cmd_op,
	input  wire logic [6:0]           cmd_index,
	input  wire logic [7:0]           cmd_count,
	// write data
	input  wire logic                 wr_valid,
	output logic                      wr_ready,
	input  wire logic [7:0]           wr_data,
	// read data and status
	output logic                      rd_valid,
	output logic [7:0]                rd_data,
	output logic                      done,
	output logic                      nack
);

	typedef enum {H_IDLE, H_START, H_ADDRW, H_CMD, H_COUNT, H_WLOAD,
	              H_WDATA, H_RSTART, H_ADDRR, H_RDCNT, H_RDATA,
	              H_STOP} smc_hst_e;

	smc_hst_e   st_q, st_d;
	smc_op_e    op_q, op_d;
	logic [7:0] tick_q, tick_d;
	logic [1:0] qtr_q, qtr_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [6:0] idx_q, idx_d;
	logic [7:0] cnt_q, cnt_d;
	logic       scl_q, scl_d;
	logic       sda_q, sda_d;
	logic       nack_q, nack_d;
	logic       rdv_q, rdv_d;
	logic [7:0] rdd_q, rdd_d;
	logic       done_q, done_d;
	logic       sda_s1_q, sda_s2_q;
	logic       active, slot_end, is_cond, is_rd, uop_end, ackbit;

	assign active   = st_q != H_IDLE && st_q != H_WLOAD;
	assign slot_end = active && tick_q == SMC_QTR_CYC - 8'h01 &&
	                  qtr_q == 2'h3;
	assign is_cond  = st_q == H_START || st_q == H_RSTART ||
	                  st_q == H_STOP;
	assign is_rd    = st_q == H_RDCNT || st_q == H_RDATA;
	assign uop_end  = slot_end && (is_cond || bit_q == SMC_ACK_SLOT);
	// nack the count when nothing is wanted, and the last data byte
	assign ackbit   = st_q == H_RDCNT ? cnt_q == 8'h00 : cnt_q == 8'h01;

	assign cmd_ready = st_q == H_IDLE;
	assign wr_ready  = st_q == H_WLOAD;

	always_comb begin
		st_d   = st_q;
		op_d   = op_q;
		tick_d = tick_q;
		qtr_d  = qtr_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		idx_d  = idx_q;
		cnt_d  = cnt_q;
		scl_d  = scl_q;
		sda_d  = sda_q;
		nack_d = nack_q;
		rdv_d  = 1'b0;
		rdd_d  = rdd_q;
		done_d = 1'b0;
		if (active) begin
			scl_d  = qtr_q[1];
			tick_d = tick_q + 8'h01;
			if (tick_q == SMC_QTR_CYC - 8'h01) begin
				tick_d = 8'h00;
				qtr_d  = qtr_q + 2'h1;
			end
			// data only moves while scl is low, except start and stop
			if (qtr_q == 2'h1) begin
				if (st_q == H_STOP)
					sda_d = 1'b0;
				else if (is_cond)
					sda_d = 1'b1;
				else if (bit_q == SMC_ACK_SLOT)
					sda_d = is_rd ? ackbit : 1'b1;
				else
					sda_d = is_rd ? 1'b1 : sh_q[7];
			end else if (qtr_q == 2'h3) begin
				if (st_q == H_STOP)
					sda_d = 1'b1;
				else if (is_cond)
					sda_d = 1'b0;
			end
			if (slot_end && !is_cond) begin
				if (bit_q == SMC_ACK_SLOT) begin
					bit_d = 4'h0;
					if (!is_rd && sda_s2_q)
						nack_d = 1'b1;
				end else begin
					bit_d = bit_q + 4'h1;
					sh_d  = is_rd ? {sh_q[6:0], sda_s2_q} : {sh_q[6:0], 1'b0};
				end
			end
		end
		if (uop_end && !is_rd && !is_cond && sda_s2_q) begin
			st_d = H_STOP;
		end else if (uop_end) begin
			case (st_q)
				H_START: begin
					st_d = H_ADDRW;
					sh_d = {SMC_DEV_ADDR, 1'b0};
				end
				H_ADDRW: begin
					st_d = H_CMD;
					if (op_q == SMC_OP_BYTE_WR || op_q == SMC_OP_BYTE_RD)
						sh_d = {1'b1, idx_q};
					else
						sh_d = 8'h00;
				end
				H_CMD: begin
					if (op_q == SMC_OP_BYTE_WR) begin
						st_d = H_WLOAD;
					end else if (op_q == SMC_OP_BLK_WR) begin
						st_d = H_COUNT;
						sh_d = cnt_q;
					end else begin
						st_d = H_RSTART;
					end
				end
				H_COUNT:
					st_d = cnt_q == 8'h00 ? H_STOP : H_WLOAD;
				H_WDATA: begin
					cnt_d = cnt_q - 8'h01;
					st_d  = cnt_q == 8'h01 ? H_STOP : H_WLOAD;
				end
				H_RSTART: begin
					st_d = H_ADDRR;
					sh_d = {SMC_DEV_ADDR, 1'b1};
				end
				H_ADDRR:
					st_d = op_q == SMC_OP_BLK_RD ? H_RDCNT : H_RDATA;
				H_RDCNT:
					st_d = cnt_q == 8'h00 ? H_STOP : H_RDATA;
				H_RDATA: begin
					rdv_d = 1'b1;
					rdd_d = sh_q;
					cnt_d = cnt_q - 8'h01;
					st_d  = cnt_q == 8'h01 ? H_STOP : H_RDATA;
				end
				H_STOP: begin
					st_d   = H_IDLE;
					done_d = 1'b1;
				end
				default: ;
			endcase
		end else if (st_q == H_IDLE && cmd_valid) begin
			st_d   = H_START;
			op_d   = cmd_op;
			idx_d  = cmd_index;
			nack_d = 1'b0;
			tick_d = 8'h00;
			qtr_d  = 2'h0;
			bit_d  = 4'h0;
			if (cmd_op == SMC_OP_BYTE_WR || cmd_op == SMC_OP_BYTE_RD)
				cnt_d = 8'h01;
			else
				cnt_d = cmd_count;
		end else if (st_q == H_WLOAD && wr_valid) begin
			st_d = H_WDATA;
			sh_d = wr_data;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q     <= H_IDLE;
			op_q     <= SMC_OP_BYTE_WR;
			tick_q   <= 8'h00;
			qtr_q    <= 2'h0;
			bit_q    <= 4'h0;
			sh_q     <= 8'h00;
			idx_q    <= 7'h00;
			cnt_q    <= 8'h00;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			nack_q   <= 1'b0;
			rdv_q    <= 1'b0;
			rdd_q    <= 8'h00;
			done_q   <= 1'b0;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			st_q     <= st_d;
			op_q     <= op_d;
			tick_q   <= tick_d;
			qtr_q    <= qtr_d;
			bit_q    <= bit_d;
			sh_q     <= sh_d;
			idx_q    <= idx_d;
			cnt_q    <= cnt_d;
			scl_q    <= scl_d;
			sda_q    <= sda_d;
			nack_q   <= nack_d;
			rdv_q    <= rdv_d;
			rdd_q    <= rdd_d;
			done_q   <= done_d;
			sda_s1_q <= link.sda;
			sda_s2_q <= sda_s1_q;
		end
	end

	assign link.scl         = scl_q;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = ~sda_q;
	assign rd_valid = rdv_q;
	assign rd_data  = rdd_q;
	assign done     = done_q;
	assign nack     = nack_q;

endmodule

/* File: smc_link_props.sv */
// wire-level checker for the two-wire configuration link
`timescale 1ns/100ps
module smc_link_props
	import smc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// link
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic [3:0] byte_q;
	logic [7:0] sh_q;
	logic       rd_q;
	logic       blk_q;
	logic       match_q;
	logic       start;
	logic       rise;
	logic       last;

	assign start = scl & scl_q & sda_q & ~sda;
	assign rise  = scl & ~scl_q;
	assign last  = rise & (bit_q == 4'h7);

	// scl is divided from mclk, so sampling on mclk misses no edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			bit_q   <= 4'h0;
			byte_q  <= 4'h0;
			sh_q    <= 8'h00;
			rd_q    <= 1'b0;
			blk_q   <= 1'b0;
			match_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bit_q  <= 4'h0;
				byte_q <= 4'h0;
			end else if (rise && bit_q == SMC_ACK_SLOT) begin
				bit_q <= 4'h0;
				if (byte_q != 4'hF)
					byte_q <= byte_q + 4'h1;
				if (byte_q == 4'h0) begin
					rd_q    <= sh_q[0];
					match_q <= (sh_q[7:1] == SMC_DEV_ADDR);
				end
				if (byte_q == 4'h1 && !rd_q)
					blk_q <= ~sh_q[7];
			end else if (rise) begin
				bit_q <= bit_q + 4'h1;
				sh_q  <= {sh_q[6:0], sda};
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	addr_ack_a: assert property (
		rise && bit_q == SMC_ACK_SLOT && byte_q == 4'h0
		|-> sda == (sh_q[7:1] != SMC_DEV_ADDR))
		else $error("address acknowledge wrong");
	addr_order_a: assert property (
		last && byte_q == 4'h0 |-> {sh_q[6:0], sda} inside {8'hD2, 8'hD3})
		else $error("address byte not msb first");
	cmd_ack_a: assert property (
		rise && bit_q == SMC_ACK_SLOT && byte_q == 4'h1 && match_q && !rd_q
		|-> !sda)
		else $error("command byte not acknowledged");
	blk_cmd_a: assert property (
		last && byte_q == 4'h1 && !rd_q && !sh_q[6]
		|-> {sh_q[5:0], sda} == 7'h00)
		else $error("block command low bits not zero");
	rd_count_a: assert property (
		last && byte_q == 4'h1 && rd_q && blk_q && match_q
		|-> {sh_q[6:0], sda} == 8'(SMC_NBYTES))
		else $error("block read count byte wrong");
	drive_low_a: assert property (
		$changed(dev_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	ack_hold_a: assert property (
		$rose(scl) && dev_sda_oe |-> dev_sda_oe [*4])
		else $error("device released data during clock high");
	open_drain_a: assert property (
		(dev_sda_oe |-> !dev_sda_o) and (host_sda_oe |-> !host_sda_o))
		else $error("data line driven high");
	reset_idle_a: assert property (
		$fell(rst) |-> scl && sda && !dev_sda_oe)
		else $error("link not idle after reset");

	cover property (last && byte_q == 4'h1 && rd_q && blk_q);
	cover property (start && byte_q != 4'h0);
	cover property (rise && bit_q == SMC_ACK_SLOT && byte_q == 4'h2);
endmodule

/* File: smbus_config_slave_bench.sv */
// self-checking bench: host end and device end joined by the link
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module smbus_config_slave_bench
	import smc_pkg::*;
;
	logic                    mclk;
	logic                    rst;
	logic                    cfg_hold;
	logic                    cmd_valid;
	logic                    cmd_ready;
	smc_op_e                 cmd_op;
	logic [6:0]              cmd_index;
	logic [7:0]              cmd_count;
	logic                    wr_valid;
	logic                    wr_ready;
	logic [7:0]              wr_data;
	logic                    rd_valid;
	logic [7:0]              rd_data;
	logic                    done;
	logic                    nack;
	logic [SMC_NBYTES*8-1:0] cfg_bytes;
	logic [SMC_OUT_EN_W-1:0] out_en;
	logic                    wr_pending;
	logic [SMC_NBYTES*8-1:0] mdl;
	logic [7:0]              wb [16];
	logic [7:0]              rb [16];
	int                      n_fail;
	int                      n_checks;

	smc_link_if lnk ();
	smc_host i_smc_host (.link(lnk), .mclk(mclk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_index(cmd_index), .cmd_count(cmd_count), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .nack(nack));
	smc_dev #(.NBYTES(SMC_NBYTES)) i_smc_dev (.link(lnk), .mclk(mclk),
		.rst(rst), .cfg_hold(cfg_hold), .cfg_bytes(cfg_bytes),
		.out_en(out_en), .wr_pending(wr_pending));
	smc_link_props i_smc_link_props (.mclk(mclk), .rst(rst),
		.scl(lnk.scl), .host_sda_o(lnk.host_sda_o),
		.host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
		.dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda));

	task automatic tally_and_finish(input logic to);
		if (to)
			n_fail++;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// entered at a falling edge; all handshakes are judged there
	task automatic xfer(input smc_op_e op, input logic [6:0] idx,
		input logic [7:0] cnt);
		int   k;
		int   wi;
		int   ri;
		logic hs;
		wi = 0;
		ri = 0;
		hs = 1'b0;
		cmd_op = op;
		cmd_index = idx;
		cmd_count = cnt;
		cmd_valid = 1'b1;
		for (k = 0; k < 8000; k++) begin
			@(negedge mclk);
			cmd_valid = 1'b0;
			if (hs)
				wi++;
			if (rd_valid === 1'b1) begin
				rb[ri] = rd_data;
				ri++;
			end
			if (done === 1'b1)
				break;
			wr_valid = (wi < cnt);
			wr_data = wb[wi];
			hs = wr_valid && (wr_ready === 1'b1);
		end
		wr_valid = 1'b0;
		if (k == 8000)
			tally_and_finish(1'b1);
	endtask

	// mirror lags the link copy by a few mclk through the buffer
	task automatic drain();
		int k;
		for (k = 0; k < 200; k++) begin
			@(negedge mclk);
			if (wr_pending === 1'b0)
				break;
		end
		if (k == 200)
			tally_and_finish(1'b1);
	endtask

	task automatic t_reset();
		`CHK(cfg_bytes, mdl)
		`CHK(out_en, {mdl[22:16], mdl[15:8]})
		`CHK(wr_pending, 1'b0)
		`CHK(cmd_ready, 1'b1)
		`CHK(nack, 1'b0)
	endtask

	task automatic t_byte();
		wb[0] = 8'h5A;
		xfer(SMC_OP_BYTE_WR, 7'h07, 8'h01);
		drain();
		mdl[56+:8] = 8'h5A;
		`CHK(nack, 1'b0)
		`CHK(cfg_bytes, mdl)
		xfer(SMC_OP_BYTE_RD, 7'h07, 8'h01);
		`CHK(rb[0], 8'h5A)
		xfer(SMC_OP_BYTE_RD, 7'h01, 8'h01);
		`CHK(rb[0], SMC_DEF_BYTE1)
	endtask

	task automatic t_blk();
		wb[0] = 8'hC3;
		wb[1] = 8'h3C;
		wb[2] = 8'h96;
		xfer(SMC_OP_BLK_WR, 7'h00, 8'h03);
		drain();
		for (int k = 0; k < 3; k++)
			mdl[8*k+:8] = wb[k];
		`CHK(nack, 1'b0)
		`CHK(cfg_bytes, mdl)
		`CHK(out_en, {mdl[22:16], mdl[15:8]})
		xfer(SMC_OP_BLK_RD, 7'h00, 8'(SMC_NBYTES));
		for (int k = 0; k < SMC_NBYTES; k++)
			`CHK(rb[k], mdl[8*k+:8])
	endtask

	task automatic t_bad_index();
		wb[0] = 8'hE7;
		xfer(SMC_OP_BYTE_WR, 7'h08, 8'h01);
		drain();
		`CHK(nack, 1'b1)
		`CHK(cfg_bytes, mdl)
	endtask

	task automatic t_full();
		cfg_hold = 1'b1;
		wb[0] = 8'h11;
		wb[1] = 8'h22;
		wb[2] = 8'h44;
		wb[3] = 8'h88;
		xfer(SMC_OP_BLK_WR, 7'h00, 8'h04);
		`CHK(nack, 1'b1)
		`CHK(wr_pending, 1'b1)
		`CHK(cfg_bytes[7:0], mdl[7:0])
		cfg_hold = 1'b0;
		drain();
		`CHK(cfg_bytes[7:0], 8'h11)
		`CHK(cfg_bytes[63:24], mdl[63:24])
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		rst = 1'b1;
		cfg_hold = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = SMC_OP_BYTE_WR;
		cmd_index = 7'h00;
		cmd_count = 8'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		n_fail = 0;
		n_checks = 0;
		for (int k = 0; k < SMC_NBYTES; k++)
			mdl[8*k+:8] = SMC_DEF_OTHER;
		mdl[7:0] = SMC_DEF_BYTE0;
		mdl[15:8] = SMC_DEF_BYTE1;
		mdl[23:16] = SMC_DEF_BYTE2;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		t_reset();
		t_byte();
		t_blk();
		t_bad_index();
		t_full();
		tally_and_finish(1'b0);
	end
endmodule
